// *** bench/line_model.sv ***
// Programmer-side model that drives and samples the shared debug line
module line_model #(
  parameter int BIT = 120
) (
  input wire logic clk_in,
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_low_q = 1'b0;
  // Pull-up holds the line high when nobody drives it
  assign line_out = pin_oe_in ? pin_out_in : !drv_low_q;
  // One frame, LSB first; flags spoil parity or first stop
  task automatic send(input logic [7:0] b, input logic bp, bs);
    logic [11:0] f;
    f = {1'b1, !bs, ^b ^ bp, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      drv_low_q <= !f[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask
  // Break: line held low
  task automatic low(input int n);
    drv_low_q <= 1'b1;
    repeat (n) @(posedge clk_in);
    drv_low_q <= 1'b0;
  endtask
  // Sample a response mid-bit; caller waits for it first
  task automatic rx(output logic [11:0] f);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < 12; i++) begin
      f[i] = line_out;
      repeat (BIT) @(posedge clk_in);
    end
  endtask
endmodule

// *** bench/one_wire_debug_assertions.sv ***
// Port-level checker for the one-wire program/debug port
module one_wire_debug_assertions (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_out,
  input wire logic pin_oe_out,
  input wire logic pin_pull_en_out,
  input wire logic bus_grant_in,
  input wire logic bus_req_out,
  input wire logic [7:0] bus_addr_out,
  input wire logic [7:0] bus_wdata_out,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Store request waiting, then taken
  sequence wait_s;
    bus_req_out && !bus_grant_in;
  endsequence
  sequence grant_s;
    bus_req_out && bus_grant_in;
  endsequence
  req_hold_a: assert property (wait_s |=> bus_req_out &&
    $stable(bus_addr_out) && $stable(bus_wdata_out))
    else $error("store request not held");
  req_drop_a: assert property (grant_s |=> !bus_req_out)
    else $error("store request kept after grant");
  ack_start_a: assert property (grant_s |-> ##[1:4] $rose(pin_oe_out))
    else $error("no acknowledge after grant");
  start_low_a: assert property ($rose(pin_oe_out) |-> !pin_out)
    else $error("response start bit not low");
  oe_hold_a: assert property ($rose(pin_oe_out) |-> pin_oe_out[*8])
    else $error("response frame cut short");
  stop_high_a: assert property ($fell(pin_oe_out) |-> $past(pin_out))
    else $error("response stop bit not high");
  oe_active_a: assert property (pin_oe_out |-> pin_pull_en_out)
    else $error("pin driven while port inactive");
  rdata_zero_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
endmodule

bind one_wire_debug_port one_wire_debug_assertions u_chk (.clk_in,
  .reset_in, .pin_out, .pin_oe_out, .pin_pull_en_out, .bus_grant_in,
  .bus_req_out, .bus_addr_out, .bus_wdata_out, .reg_rd_in, .reg_rdata_out);

// *** bench/one_wire_debug_uart_phy_bench.sv ***
// Self-checking bench for the one-wire program/debug port
module one_wire_debug_uart_phy_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import one_wire_debug_pkg::*;
  // Eight fast link ticks of 15 clocks per bit
  localparam int BIT = 120;
  logic clk_in = 1'b0, reset_in = 1'b1, fuse = 1'b0, grant = 1'b0;
  logic hv = 1'b0, halt = 1'b0;
  logic wr = 1'b0, rd = 1'b0, line, pout, poe, pull, inen, req;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, baddr, bdata, rdata;
  logic [11:0] frm;
  int err_total = 0, n_checks = 0;
  one_wire_debug_port u_one_wire_debug_port (.clk_in, .reset_in,
    .pin_in(line), .pin_out(pout), .pin_oe_out(poe),
    .pin_pull_en_out(pull), .pin_in_en_out(inen),
    .reset_pin_function_config_in(fuse), .hv_override_in(hv),
    .debug_stopped_in(halt), .prog_unlocked_in(1'b0),
    .bus_grant_in(grant), .bus_req_out(req), .bus_addr_out(baddr),
    .bus_wdata_out(bdata), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));
  line_model #(.BIT(BIT)) u_line_model (.clk_in, .pin_out_in(pout),
    .pin_oe_in(poe), .line_out(line));
  // 250 MHz core clock
  initial forever #2 clk_in = ~clk_in;
  task automatic cmp(input logic [11:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] m, e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    // Taken at the next edge, the last instant the data stand
    @(posedge clk_in);
    cmp(12'(rdata & m), 12'(e));
  endtask
  // Sync, store direct, grant, then collect the acknowledge
  task automatic store(input logic bp, input logic [7:0] a);
    u_line_model.send(8'h55, 1'b0, 1'b0);
    u_line_model.send({OP_STORE_DIRECT, 5'h00}, bp, 1'b0);
    u_line_model.send(a, bp, 1'b0);
    u_line_model.send(8'h5a, bp, 1'b0);
    for (int i = 0; i < 300 && !req; i++) begin
      @(posedge clk_in);
      #1;
    end
    cmp(12'({req, baddr}), 12'({1'b1, a}));
    cmp(12'(bdata), 12'h05a);
    @(posedge clk_in);
    grant <= 1'b1;
    @(posedge clk_in);
    grant <= 1'b0;
    for (int i = 0; i < 20 && !poe; i++) begin
      @(posedge clk_in);
      #1;
    end
    u_line_model.rx(frm);
    cmp(frm, {2'b11, ^8'h40, 8'h40, 1'b0});
  endtask
  // Break clears errors and the divider, then fast link again
  task automatic recover();
    u_line_model.low(14 * BIT);
    repeat (2 * BIT) @(posedge clk_in);
    rd_reg(REG_STATUS, 8'h07, 8'h00);
    rd_reg(REG_ASI_CTRL, 8'hff, 8'h03);
    wr_reg(REG_ASI_CTRL, 8'h01);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_reg(REG_PORT_CTRL, 8'hff, 8'h00);
    rd_reg(REG_ASI_CTRL, 8'hff, 8'h03);
    rd_reg(REG_STATUS, 8'hff, 8'h00);
    rd_reg(2'h3, 8'hff, 8'h00);
    wr_reg(REG_STATUS, 8'hff);
    rd_reg(REG_STATUS, 8'hff, 8'h00);
    wr_reg(REG_PORT_CTRL, 8'h01);
    // Link settings are held at default while the port is inactive
    rd_reg(REG_PORT_CTRL, 8'hff, 8'h00);
    wr_reg(REG_PORT_CTRL, 8'h00);
    // High-voltage override alone claims the pin
    hv <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd_reg(REG_STATUS, 8'h08, 8'h08);
    // Fuse takes over as the override goes away
    fuse <= 1'b1;
    hv <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 cmp(12'({pull, inen}), 12'h003);
    rd_reg(REG_STATUS, 8'h08, 8'h08);
    wr_reg(REG_ASI_CTRL, 8'h01);
    rd_reg(REG_ASI_CTRL, 8'hff, 8'h01);
    store(1'b0, 8'h10);
    repeat (13 * BIT) @(posedge clk_in);
    rd_reg(REG_STATUS, 8'h20, 8'h20);
    u_line_model.send(8'h55, 1'b0, 1'b0);
    u_line_model.send(8'h40, 1'b1, 1'b0);
    rd_reg(REG_STATUS, 8'h07, 8'h01);
    recover();
    u_line_model.send(8'h55, 1'b0, 1'b0);
    u_line_model.send(8'h40, 1'b0, 1'b1);
    rd_reg(REG_STATUS, 8'h07, 8'h02);
    recover();
    // Protected store without key is refused with no request
    u_line_model.send(8'h55, 1'b0, 1'b0);
    u_line_model.send({OP_STORE_DIRECT, 5'h00}, 1'b0, 1'b0);
    u_line_model.send(PROT_BASE, 1'b0, 1'b0);
    u_line_model.send(8'h33, 1'b0, 1'b0);
    cmp(12'(req), 12'h000);
    rd_reg(REG_STATUS, 8'h17, 8'h04);
    // Key through the interface store, no bus request
    u_line_model.send(8'h55, 1'b0, 1'b0);
    u_line_model.send({OP_ASI_STORE, 5'h03}, 1'b0, 1'b0);
    u_line_model.send(KEY_VALUE, 1'b0, 1'b0);
    cmp(12'(req), 12'h000);
    rd_reg(REG_STATUS, 8'h17, 8'h14);
    halt <= 1'b1;
    wr_reg(REG_PORT_CTRL, 8'h01);
    store(1'b1, PROT_BASE);
    print_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end
endmodule

// *** rtl/link_rx.sv ***
// Link receiver: sync measurement, frame checks, idle and break detection
module link_rx (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic flush_in,
  input wire logic enable_in,
  input wire logic line_in,
  input wire logic sync_mode_in,
  input wire logic parity_disable_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic parity_err_out,
  output logic frame_err_out,
  output logic sync_done_out,
  output logic recover_err_out,
  output logic break_out,
  output logic idle_out,
  output logic [one_wire_debug_pkg::BITLEN_W-1:0] bit_len_out
);
  import one_wire_debug_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_RUN} rx_state_e;
  typedef struct packed {
    rx_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] edges;
    logic [3:0] bitn;
    logic [11:0] shreg;
    logic [BITLEN_W-1:0] bit_len;
    logic [LONG_W-1:0] low_cnt;
    logic [LONG_W-1:0] high_cnt;
    logic prev;
    logic valid;
    logic perr;
    logic ferr;
    logic sync;
    logic rerr;
    logic brk;
    logic idle;
  } rx_s;
  rx_s q, d;

  // Twelve bit times at the current baud
  function automatic logic [LONG_W-1:0] frame_span(
    input logic [BITLEN_W-1:0] len);
    return LONG_W'(len) * LONG_W'(FRAME_BITS);
  endfunction

  // All link-side work except a flush happens on the link tick only
  always_comb begin
    logic [11:0] nsh;
    nsh = q.shreg;
    d = q;
    d.valid = 1'b0;
    d.perr = 1'b0;
    d.ferr = 1'b0;
    d.sync = 1'b0;
    d.rerr = 1'b0;
    d.brk = 1'b0;
    d.idle = 1'b0;
    if (flush_in) begin
      d.st = RX_IDLE;
      d.bit_len = BITLEN_RESET;
      d.low_cnt = '0;
      d.high_cnt = '0;
      d.prev = 1'b1;
    end else if (tick_in) begin
      d.prev = line_in;
      // Level run counters saturate so a stuck line cannot wrap
      if (!line_in) begin
        d.high_cnt = '0;
        if (q.low_cnt != '1) d.low_cnt = q.low_cnt + 1'b1;
      end else begin
        d.low_cnt = '0;
        if (q.high_cnt != '1) d.high_cnt = q.high_cnt + 1'b1;
      end
      case (q.st)
        RX_IDLE: begin
          if (enable_in && q.prev && !line_in) begin
            d.cnt = '0;
            d.edges = '0;
            d.bitn = '0;
            if (sync_mode_in) begin
              d.st = RX_MEAS;
            end else begin
              d.st = RX_RUN;
              d.cnt = CNT_W'(q.bit_len >> 1); // Centre of the start bit
            end
          end
        end
        RX_MEAS: begin
          d.cnt = q.cnt + 1'b1;
          if (q.prev && !line_in) begin
            // Fifth falling edge of 0x55 ends eight bit times; see (R22)
            if (q.edges == SYNC_LAST_EDGE) begin
              d.bit_len = BITLEN_W'((q.cnt + 1'b1) >> SYNC_SHIFT); // see (R11)
              d.sync = 1'b1;
              d.st = RX_IDLE;
            end else begin
              d.edges = q.edges + 1'b1;
            end
          end else if (q.cnt == '1) begin
            d.rerr = 1'b1; // Too slow to measure; see (R19)
            d.st = RX_IDLE;
          end
        end
        RX_RUN: begin
          if (q.cnt == '0) begin
            nsh = {line_in, q.shreg[11:1]};
            d.shreg = nsh;
            d.cnt = CNT_W'(q.bit_len - 1'b1); // Measured baud only; see (R16)
            d.bitn = q.bitn + 1'b1;
            if (q.bitn == FRAME_LAST) begin
              d.st = RX_IDLE;
              // Start low, data, parity, two high stops; see (R06)
              if (nsh[0] || !nsh[10] || !nsh[11]) begin
                d.ferr = 1'b1; // see (R07) (R26)
              end else if (!parity_disable_in &&
                           even_parity(nsh[8:1]) != nsh[9]) begin
                d.perr = 1'b1; // see (R07) (R08)
              end else begin
                d.valid = 1'b1;
              end
            end
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        default: d.st = RX_IDLE;
      endcase
      // Break wins over any frame in flight; see (R10)
      if (q.low_cnt == frame_span(q.bit_len)) begin
        d.brk = 1'b1;
        d.st = RX_IDLE;
        d.bit_len = BITLEN_RESET;
      end else if (q.high_cnt == frame_span(q.bit_len)) begin
        d.idle = 1'b1; // see (R09)
      end
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.bit_len <= BITLEN_RESET;
      q.prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign byte_valid_out = q.valid;
  assign byte_out = q.shreg[8:1];
  assign parity_err_out = q.perr;
  assign frame_err_out = q.ferr;
  assign sync_done_out = q.sync;
  assign recover_err_out = q.rerr;
  assign break_out = q.brk;
  assign idle_out = q.idle;
  assign bit_len_out = q.bit_len;
endmodule

// *** rtl/link_tx.sv ***
// Link transmitter: twelve-bit response frames at the measured baud
module link_tx (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic flush_in,
  input wire logic start_in,
  input wire logic [7:0] byte_in,
  input wire logic [one_wire_debug_pkg::BITLEN_W-1:0] bit_len_in,
  output logic line_out,
  output logic drive_out,
  output logic busy_out,
  output logic done_out
);
  import one_wire_debug_pkg::*;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
  typedef struct packed {
    tx_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bitn;
    logic [11:0] shreg;
    logic line;
    logic drive;
    logic done;
  } tx_s;
  tx_s q, d;

  // Shift out start, data, even parity and two stops; see (R25)
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (flush_in) begin
      d.st = TX_IDLE;
      d.line = 1'b1;
      d.drive = 1'b0;
    end else begin
      case (q.st)
        TX_IDLE: begin
          if (start_in) begin
            d.shreg = {2'b11, even_parity(byte_in), byte_in, 1'b0};
            d.st = TX_SEND;
            d.bitn = '0;
            d.cnt = CNT_W'(bit_len_in - 1'b1); // Same baud as receive; see (R15)
            d.line = 1'b0;
            d.drive = 1'b1;
          end
        end
        TX_SEND: begin
          if (tick_in) begin
            if (q.cnt != '0) begin
              d.cnt = q.cnt - 1'b1;
            end else if (q.bitn == FRAME_LAST) begin
              d.st = TX_IDLE;
              d.line = 1'b1;
              d.drive = 1'b0; // Release the shared line after stop bits
              d.done = 1'b1;
            end else begin
              d.bitn = q.bitn + 1'b1;
              d.shreg = q.shreg >> 1;
              d.line = q.shreg[1];
              d.cnt = CNT_W'(bit_len_in - 1'b1);
            end
          end
        end
        default: d.st = TX_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign line_out = q.line;
  assign drive_out = q.drive;
  assign busy_out = (q.st == TX_SEND);
  assign done_out = q.done;
endmodule

// *** rtl/one_wire_debug_pkg.sv ***
// Shared constants and helpers for the one-wire program/debug port
package one_wire_debug_pkg;
  // Core clock and link clock rates
  localparam int CLK_MHZ = 250;
  localparam int LINK_MHZ_FAST = 16;
  localparam int LINK_MHZ_MID = 8;
  localparam int LINK_MHZ_SLOW = 4;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_MHZ / LINK_MHZ_FAST - 1);
  localparam logic [DIV_W-1:0] DIV_MID = DIV_W'(CLK_MHZ / LINK_MHZ_MID - 1);
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_MHZ / LINK_MHZ_SLOW - 1);
  // Link clock divider select encodings
  localparam logic [1:0] CLKSEL_FAST = 2'h1;
  localparam logic [1:0] CLKSEL_MID = 2'h2;
  localparam logic [1:0] CLKSEL_SLOW = 2'h3;
  localparam logic [1:0] CLKSEL_RESET = CLKSEL_SLOW;
  // Frame layout and baud measurement
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] FRAME_LAST = 4'hb;
  localparam int CNT_W = 16;
  localparam int BITLEN_W = 13;
  localparam int LONG_W = 18;
  localparam logic [BITLEN_W-1:0] BITLEN_RESET = 13'h1fff;
  localparam logic [2:0] SYNC_LAST_EDGE = 3'h3;
  localparam int SYNC_SHIFT = 3;
  localparam logic [7:0] ACK_CHAR = 8'h40;
  // Register port map and fields
  localparam logic [1:0] REG_PORT_CTRL = 2'h0;
  localparam logic [1:0] REG_ASI_CTRL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int PARITY_CHECK_DISABLE_BIT = 0;
  localparam int ST_ACTIVE = 3;
  localparam int ST_KEY = 4;
  localparam int ST_IDLE = 5;
  localparam int ST_BUSY = 6;
  // Instruction opcodes in bits 7:5, interface index in bits 1:0
  localparam logic [2:0] OP_STORE_DIRECT = 3'h2;
  localparam logic [2:0] OP_STORE_PTR = 3'h3;
  localparam logic [2:0] OP_ASI_STORE = 3'h6;
  localparam logic [1:0] ASI_PORT_CTRL = 2'h0;
  localparam logic [1:0] ASI_CLK_CTRL = 2'h1;
  localparam logic [1:0] ASI_PTR = 2'h2;
  localparam logic [7:0] PROT_BASE = 8'hc0;
  localparam logic [7:0] KEY_VALUE = 8'ha5;
  // Error signatures
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_PARITY = 3'h1;
  localparam logic [2:0] ERR_FRAME = 3'h2;
  localparam logic [2:0] ERR_CLOCK = 3'h3;
  localparam logic [2:0] ERR_SYSTEM = 3'h4;

  // Even parity over one data byte
  function automatic logic even_parity(input logic [7:0] b);
    return ^b;
  endfunction
endpackage

// *** rtl/one_wire_debug_port.sv ***
// Top of the one-wire program/debug port: link, data link and bus access
// Function
// (R01) Split into physical link, instruction data link, and bus access layers.
// (R02) Half-duplex receive and transmit on one reset pin, link clocked apart.
// (R03) Link and bus sides use separate rates, joined through a handshake.
// (R04) Link clock starts at 4 MHz after enable or reset.
// (R05) Writing the divider select field changes the link clock.
// (R06) Frame: low start, eight data, even parity, two high stops.
// (R07) Wrong parity or stop bit is detected and reported as error.
// (R08) Parity disable bit skips the receive parity check.
// (R09) Idle is line high for twelve or more bit times.
// (R10) Line low twelve bit times is break; everything returns to default. Here ptr keeps its value.
// (R11) Sync is expected before each instruction and after break.
// (R12) Acknowledge is sent once a store obtains system bus access.
// (R13) Debugger waits for acknowledge before its next transmission.
// (R14) Debugger starts all traffic, each transmission opening with sync.
// (R15) Measured baud is used for both receiving and transmitting.
// (R16) No writable baud setting; sampling rate only from sync measurement.
// (R17) Active port drives pull-up, input enable and output enable itself.
// (R18) Pin belongs to the port only by fuse or high-voltage override.
// (R19) Parity, clock recovery, frame and system errors give signatures.
// (R20) Protected addresses need key plus stopped or unlocked state.
// (R21) Interface registers are reached without requesting the system bus.
// (R22) Sync character is eight bits of fixed value 0x55.
// (R23) Break returns the divider select to the 4 MHz setting.
// (R24) Divider select: 1 is 16 MHz, 2 is 8 MHz, 3 is 4 MHz default.
// (R25) Responses use the same twelve-bit even-parity two-stop frame.
// (R26) Low first stop bit is a frame error aborting the operation.
//
// Chosen here: the address map and the address-and-strobe port.
module one_wire_debug_port (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic pin_pull_en_out,
  output logic pin_in_en_out,
  input wire logic reset_pin_function_config_in,
  input wire logic hv_override_in,
  input wire logic debug_stopped_in,
  input wire logic prog_unlocked_in,
  input wire logic bus_grant_in,
  output logic bus_req_out,
  output logic [7:0] bus_addr_out,
  output logic [7:0] bus_wdata_out,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  import one_wire_debug_pkg::*;

  typedef enum logic [2:0] {
    DL_SYNC, DL_INSTR, DL_ADDR, DL_DATA, DL_XFER, DL_ACK, DL_ERR
  } dl_state_e;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic fuse_s1;
    logic fuse_s2;
    logic hv_s1;
    logic hv_s2;
    logic active;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    dl_state_e dl;
    logic [7:0] instr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] ptr;
    logic [7:0] xfer_addr;
    logic parity_check_disable;
    logic [1:0] link_clock_divider_select;
    logic key_ok;
    logic line_idle;
    logic [2:0] err;
    logic req_tgl;
    logic ack_tgl;
    logic bus_req;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic tx_start;
    logic [7:0] rdata;
    logic pin_o;
    logic pin_oe;
    logic pull_en;
    logic in_en;
  } top_s;
  top_s q, d;

  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_perr;
  logic rx_ferr;
  logic rx_sync;
  logic rx_rerr;
  logic rx_brk;
  logic rx_idle;
  logic [BITLEN_W-1:0] bit_len;
  logic tx_line;
  logic tx_drive;
  logic tx_busy;
  logic tx_done;

  // Physical link receiver, quiet while we talk on the shared line
  link_rx u_link_rx (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(q.tick),
    .flush_in(!q.active),
    .enable_in(q.active && !tx_busy),
    .line_in(q.pin_s2),
    .sync_mode_in(q.dl == DL_SYNC),
    .parity_disable_in(q.parity_check_disable),
    .byte_valid_out(rx_valid),
    .byte_out(rx_byte),
    .parity_err_out(rx_perr),
    .frame_err_out(rx_ferr),
    .sync_done_out(rx_sync),
    .recover_err_out(rx_rerr),
    .break_out(rx_brk),
    .idle_out(rx_idle),
    .bit_len_out(bit_len)
  );

  // Physical link transmitter, aborted by a break or loss of the pin
  link_tx u_link_tx (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(q.tick),
    .flush_in(!q.active || rx_brk),
    .start_in(q.tx_start),
    .byte_in(ACK_CHAR),
    .bit_len_in(bit_len),
    .line_out(tx_line),
    .drive_out(tx_drive),
    .busy_out(tx_busy),
    .done_out(tx_done)
  );

  // Next-state logic for every layer held in this module
  always_comb begin
    logic pending;
    logic [7:0] target;
    logic [DIV_W-1:0] lim;
    pending = 1'b0;
    target = 8'h00;
    lim = DIV_SLOW;
    d = q;
    d.tx_start = 1'b0;
    d.tick = 1'b0;

    // Pin-side levels pass two flops before use
    d.pin_s1 = pin_in;
    d.pin_s2 = q.pin_s1;
    d.fuse_s1 = reset_pin_function_config_in;
    d.fuse_s2 = q.fuse_s1;
    d.hv_s1 = hv_override_in;
    d.hv_s2 = q.hv_s1;
    d.active = q.fuse_s2 || q.hv_s2; // Never via general port setup; see (R18)

    // Link rate enable; integer division makes 16 MHz run slightly fast
    case (q.link_clock_divider_select)
      CLKSEL_FAST: lim = DIV_FAST; // see (R24)
      CLKSEL_MID: lim = DIV_MID;
      default: lim = DIV_SLOW;
    endcase
    if (q.div_cnt >= lim) begin // see (R05)
      d.div_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
    end

    // Software register port; read data valid one cycle later only
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_PORT_CTRL: d.parity_check_disable = reg_wdata_in[PARITY_CHECK_DISABLE_BIT];
        REG_ASI_CTRL: d.link_clock_divider_select = reg_wdata_in[1:0];
        default: ;
      endcase
    end
    d.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_PORT_CTRL: d.rdata[PARITY_CHECK_DISABLE_BIT] = q.parity_check_disable;
        REG_ASI_CTRL: d.rdata[1:0] = q.link_clock_divider_select;
        REG_STATUS: begin
          d.rdata[2:0] = q.err;
          d.rdata[ST_ACTIVE] = q.active;
          d.rdata[ST_KEY] = q.key_ok;
          d.rdata[ST_IDLE] = q.line_idle;
          d.rdata[ST_BUSY] = (q.dl != DL_SYNC) && (q.dl != DL_ERR);
        end
        default: ;
      endcase
    end

    // Bus side of the toggle handshake; see (R03)
    pending = q.req_tgl ^ q.ack_tgl;
    if (q.bus_req) begin
      if (bus_grant_in) begin
        d.bus_req = 1'b0;
        d.ack_tgl = ~q.ack_tgl;
      end
    end else if (pending) begin
      d.bus_req = 1'b1;
      d.bus_addr = q.xfer_addr;
      d.bus_wdata = q.data;
    end

    // Data link: instruction decode and access setup; see (R01)
    if (!q.active || rx_brk) begin
      d.dl = DL_SYNC; // see (R10) (R11)
      d.link_clock_divider_select = CLKSEL_RESET; // see (R04) (R23)
      d.parity_check_disable = 1'b0;
      d.key_ok = 1'b0;
      d.line_idle = 1'b0;
      d.err = ERR_NONE;
    end else begin
      if (rx_idle) d.line_idle = 1'b1;
      if (rx_valid || rx_sync) d.line_idle = 1'b0;
      if (rx_perr) begin
        d.err = ERR_PARITY; // see (R19)
        d.dl = DL_ERR;
      end else if (rx_ferr) begin
        d.err = ERR_FRAME; // Held until a break or pin loss, unless a later parity error replaces it; see (R26)
        d.dl = DL_ERR;
      end else if (rx_rerr) begin
        d.err = ERR_CLOCK; // see (R19)
        d.dl = DL_ERR;
      end else begin
        case (q.dl)
          DL_SYNC: if (rx_sync) d.dl = DL_INSTR; // see (R11)
          DL_INSTR: begin
            if (rx_valid) begin
              d.instr = rx_byte;
              case (rx_byte[7:5])
                OP_STORE_DIRECT: d.dl = DL_ADDR;
                OP_STORE_PTR: d.dl = DL_DATA;
                OP_ASI_STORE: d.dl = DL_DATA;
                default: begin
                  d.err = ERR_SYSTEM;
                  d.dl = DL_SYNC;
                end
              endcase
            end
          end
          DL_ADDR: begin
            if (rx_valid) begin
              d.addr = rx_byte;
              d.dl = DL_DATA;
            end
          end
          DL_DATA: begin
            if (rx_valid) begin
              d.data = rx_byte;
              if (q.instr[7:5] == OP_ASI_STORE) begin
                // Interface registers, no system bus involved; see (R21)
                case (q.instr[1:0])
                  ASI_PORT_CTRL: d.parity_check_disable = rx_byte[PARITY_CHECK_DISABLE_BIT];
                  ASI_CLK_CTRL: d.link_clock_divider_select = rx_byte[1:0];
                  ASI_PTR: d.ptr = rx_byte;
                  default: d.key_ok = (rx_byte == KEY_VALUE);
                endcase
                d.dl = DL_SYNC;
              end else begin
                target = (q.instr[7:5] == OP_STORE_DIRECT) ? q.addr : q.ptr;
                if (target >= PROT_BASE && !(q.key_ok &&
                    (debug_stopped_in || prog_unlocked_in))) begin
                  d.err = ERR_SYSTEM; // Refused store; see (R20)
                  d.dl = DL_SYNC;
                end else begin
                  d.xfer_addr = target;
                  d.req_tgl = ~q.req_tgl; // see (R03)
                  if (q.instr[7:5] == OP_STORE_PTR) d.ptr = q.ptr + 1'b1;
                  d.dl = DL_XFER;
                end
              end
            end
          end
          DL_XFER: begin
            if (!pending) begin
              d.tx_start = 1'b1; // Bus granted, answer now; see (R12)
              d.dl = DL_ACK;
            end
          end
          DL_ACK: if (tx_done) d.dl = DL_SYNC; // see (R13)
          DL_ERR: ;
          default: d.dl = DL_SYNC;
        endcase
      end
    end

    // Pin control overrides ordinary port settings; see (R17) (R02)
    d.pull_en = q.active;
    d.in_en = q.active;
    d.pin_oe = q.active && tx_drive;
    d.pin_o = q.active && tx_line;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.link_clock_divider_select <= CLKSEL_RESET; // see (R04)
      q.pin_s1 <= 1'b1;
      q.pin_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.pin_o;
  assign pin_oe_out = q.pin_oe;
  assign pin_pull_en_out = q.pull_en;
  assign pin_in_en_out = q.in_en;
  assign bus_req_out = q.bus_req;
  assign bus_addr_out = q.bus_addr;
  assign bus_wdata_out = q.bus_wdata;
  assign reg_rdata_out = q.rdata;
endmodule
